// ### test_table_pointer_access.sv
// Self-checking testbench for the table pointer access block.
`timescale 1ns/1ps
`include "tpa_cfg.svh"

module test_table_pointer_access;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    logic sfrWrEn = 1'b0;
    logic [1:0] sfrSel = 2'h0;
    logic [7:0] sfrWrData = 8'h00;
    logic opValid = 1'b0;
    logic opIsWrite = 1'b0;
    tpa_pkg::tpa_ptr_mode_t opMode = tpa_pkg::TPA_PTR_KEEP;
    logic wordWriteMode = 1'b0;
    logic flashWrStart = 1'b0;
    logic flashEraseSel = 1'b0;
    logic [5:0] holdRdAddr = 6'h00;
    logic slow = 1'b0;
    logic [7:0] progRdData, tableTransferLatch, pointerLowByte, pointerHighByte, pointerUpperByte;
    logic opBusy, opDone, progRdReq, progRdValid, configSpaceSel, flashGo, flashErase, adOe;
    logic highWriteStrobe, lowWriteStrobe, byteAddressPin, upperByteSelect, lowerByteSelect;
    logic [21:0] progRdAddr, extAddr;
    logic [11:0] flashBlockAddr;
    logic [15:0] holdRdData, adOut;
    logic [15:0] word = 16'h0000;
    logic [3:0] strobeSel = 4'h0;
    logic [21:0] strobeAddr = 22'h00_0000;
    int mismatches = 0;
    int compares = 0;
    wire [21:0] ptr = {pointerUpperByte[5:0], pointerHighByte, pointerLowByte};

    tpa_table_pointer_access tpa_table_pointer_access_inst (.*);
    tpa_prog_mem_model tpa_prog_mem_model_inst (.core_clk(core_clk), .rst_n(rst_n),
        .slow(slow), .progRdReq(progRdReq), .progRdAddr(progRdAddr),
        .progRdData(progRdData), .progRdValid(progRdValid));

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Access tasks.
    // ----------------------------------------
    task automatic chk(input logic [21:0] got, input logic [21:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic sfr(input logic [1:0] sel, input logic [7:0] d);
        @(posedge core_clk);
        sfrWrEn <= 1'b1;
        sfrSel <= sel;
        sfrWrData <= d;
        @(posedge core_clk);
        sfrWrEn <= 1'b0;
    endtask
    task automatic setPtr(input logic [21:0] p);
        sfr(2'h3, {2'h0, p[21:16]});
        sfr(2'h2, p[15:8]);
        sfr(2'h1, p[7:0]);
    endtask
    task automatic op(input logic wr, input tpa_pkg::tpa_ptr_mode_t m);
        int n;
        @(posedge core_clk);
        opValid <= 1'b1;
        opIsWrite <= wr;
        opMode <= m;
        @(posedge core_clk);
        opValid <= 1'b0;
        #1;
        for (n = 0; n < 20 && opDone !== 1'b1; n++) begin
            if (highWriteStrobe === 1'b1) begin
                word = adOut;
                strobeSel = {upperByteSelect, lowerByteSelect, byteAddressPin, lowWriteStrobe};
                strobeAddr = extAddr;
            end
            @(posedge core_clk);
            #1;
        end
        chk({20'h0, opDone, opBusy}, 22'h00_0002);
    endtask
    task automatic rd(input tpa_pkg::tpa_ptr_mode_t m, input logic [21:0] a, input logic [21:0] p);
        op(1'b0, m);
        chk(progRdAddr, a);
        chk({14'h0, tableTransferLatch}, {14'h0, a[7:0] ^ a[15:8] ^ {a[21], 2'h0, a[20:16]}});
        chk({21'h0, configSpaceSel}, {21'h0, a[21]});
        chk(ptr, p);
    endtask
    task automatic wrByte(input logic [7:0] d, input tpa_pkg::tpa_ptr_mode_t m);
        sfr(2'h0, d);
        op(1'b1, m);
    endtask
    task automatic hold(input logic [5:0] a, input logic [15:0] mask, input logic [15:0] exp);
        @(posedge core_clk);
        holdRdAddr <= a;
        @(posedge core_clk);
        #1;
        chk({6'h0, holdRdData & mask}, {6'h0, exp});
    endtask
    task automatic flash(input logic e);
        @(posedge core_clk);
        flashWrStart <= 1'b1;
        flashEraseSel <= e;
        @(posedge core_clk);
        flashWrStart <= 1'b0;
        #1;
        chk({8'h0, flashGo, flashErase, flashBlockAddr}, {8'h0, 1'b1, e, 12'hAAF});
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // Tests.
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        chk(ptr, 22'h00_0000);
        chk({14'h0, tableTransferLatch}, 22'h00_0000);
        setPtr(22'h3F_FFFF);
        sfr(2'h3, 8'hFF);
        #1;
        chk({14'h0, pointerUpperByte}, 22'h00_003F);
        clkEn <= 1'b0;
        sfr(2'h1, 8'h00);
        clkEn <= 1'b1;
        chk(ptr, 22'h3F_FFFF);
        $display("test registers done");
        rd(tpa_pkg::TPA_PTR_POST_INC, 22'h3F_FFFF, 22'h20_0000);
        rd(tpa_pkg::TPA_PTR_POST_DEC, 22'h20_0000, 22'h3F_FFFF);
        rd(tpa_pkg::TPA_PTR_PRE_INC, 22'h20_0000, 22'h20_0000);
        slow <= 1'b1;
        setPtr(22'h01_2345);
        rd(tpa_pkg::TPA_PTR_KEEP, 22'h01_2345, 22'h01_2345);
        slow <= 1'b0;
        $display("test reads done");
        setPtr(22'h00_007E);
        wrByte(8'hA1, tpa_pkg::TPA_PTR_POST_INC);
        wrByte(8'hB2, tpa_pkg::TPA_PTR_POST_INC);
        wrByte(8'hC3, tpa_pkg::TPA_PTR_KEEP);
        hold(6'h3F, 16'hFFFF, 16'hB2A1);
        hold(6'h00, 16'h00FF, 16'h00C3);
        $display("test holding done");
        wordWriteMode <= 1'b1;
        setPtr(22'h00_0100);
        wrByte(8'h34, tpa_pkg::TPA_PTR_POST_INC);
        chk({6'h0, word}, 22'h00_0000);
        chk(extAddr, 22'h00_0100);
        wrByte(8'h12, tpa_pkg::TPA_PTR_POST_INC);
        chk({6'h0, word}, 22'h00_1234);
        chk({18'h0, strobeSel}, 22'h00_000E);
        chk(strobeAddr, 22'h00_0101);
        rd(tpa_pkg::TPA_PTR_KEEP, 22'h00_0102, 22'h00_0102);
        wordWriteMode <= 1'b0;
        $display("test word write done");
        setPtr(22'h2A_BFFF);
        flash(1'b0);
        flash(1'b1);
        $display("test flash start done");
        wrap_up;
    end

    initial begin
        repeat (3000) @(posedge core_clk);
        mismatches++;
        wrap_up;
    end
endmodule // test_table_pointer_access

// ### tpa_cfg.svh
// Constants for the table pointer access block.
`ifndef TPA_CFG_SVH
`define TPA_CFG_SVH

`define TPA_PTR_W 22
`define TPA_LOW_W 21
`define TPA_TOP_BIT 21
`define TPA_LOW_HI 20
`define TPA_BLK_HI 21
`define TPA_BLK_LO 10
`define TPA_BLK_W 12
`define TPA_HOLD_HI 6
`define TPA_HOLD_LO 1
`define TPA_HOLD_AW 6
`define TPA_HOLD_DEPTH 64
`define TPA_LANE_BIT 0
`define TPA_BYTE_W 8
`define TPA_WORD_W 16
`define TPA_UPPER_USED 6
`define TPA_LOW_ONE 21'h00_0001
`define TPA_PTR_RST 22'h00_0000
`define TPA_BYTE_RST 8'h00
`define TPA_WORD_RST 16'h0000
`define TPA_BLK_RST 12'h000
`define TPA_UPPER_PAD 2'h0
`define TPA_SFR_LATCH 2'h0
`define TPA_SFR_PTR_LOW 2'h1
`define TPA_SFR_PTR_HIGH 2'h2
`define TPA_SFR_PTR_UPPER 2'h3

`endif

// ### tpa_hold_mem.sv
// Holding register memory: byte-lane writes, registered read data.
`timescale 1ns/1ps
`include "tpa_cfg.svh"

module tpa_hold_mem (
    input wire logic core_clk,
    input wire logic clkEn,
    input wire logic wrEn,
    input wire logic [`TPA_HOLD_AW-1:0] wrAddr,
    input wire logic wrLane,
    input wire logic [`TPA_BYTE_W-1:0] wrData,
    input wire logic [`TPA_HOLD_AW-1:0] rdAddr,
    output logic [`TPA_WORD_W-1:0] rdData
);

    logic [`TPA_WORD_W-1:0] mem [`TPA_HOLD_DEPTH];

    always_ff @(posedge core_clk) begin
        if (clkEn) begin
            if (wrEn && wrLane) begin
                mem[wrAddr][`TPA_WORD_W-1:`TPA_BYTE_W] <= wrData;
            end
            if (wrEn && !wrLane) begin
                mem[wrAddr][`TPA_BYTE_W-1:0] <= wrData;
            end
            rdData <= mem[rdAddr];
        end
    end

endmodule // tpa_hold_mem

// ### tpa_pkg.sv
// Types shared by the table pointer access block.
package tpa_pkg;

    typedef enum logic [1:0] {
        TPA_PTR_KEEP,
        TPA_PTR_POST_INC,
        TPA_PTR_POST_DEC,
        TPA_PTR_PRE_INC
    } tpa_ptr_mode_t;

    typedef enum logic [1:0] {
        TPA_ST_IDLE,
        TPA_ST_RD_WAIT,
        TPA_ST_EXT_CYCLE
    } tpa_state_t;

endpackage

// ### tpa_prog_mem_model.sv
// Program memory model answering table read requests promptly or slowly.
`timescale 1ns/1ps

module tpa_prog_mem_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic progRdReq,
    input wire logic [21:0] progRdAddr,
    output logic [7:0] progRdData,
    output logic progRdValid
);
    logic [2:0] cnt;
    // Data is valid only in the answer cycle; it toggles otherwise.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 3'h0;
            progRdValid <= 1'b0;
            progRdData <= 8'h00;
        end else begin
            progRdValid <= 1'b0;
            progRdData <= ~progRdData;
            if (progRdReq) cnt <= slow ? 3'h4 : 3'h1;
            else if (cnt != 3'h0) cnt <= cnt - 3'h1;
            if (cnt == 3'h1) begin
                progRdValid <= 1'b1;
                progRdData <= progRdAddr[7:0] ^ progRdAddr[15:8]
                    ^ {progRdAddr[21], 2'h0, progRdAddr[20:16]};
            end
        end
    end
endmodule // tpa_prog_mem_model

// ### tpa_ptr_step.sv
// Pointer update unit: access address and updated pointer for one table operation.
`timescale 1ns/1ps
`include "tpa_cfg.svh"

module tpa_ptr_step (
    input wire logic [`TPA_PTR_W-1:0] ptrIn,
    input wire tpa_pkg::tpa_ptr_mode_t mode,
    output logic [`TPA_PTR_W-1:0] accessAddr,
    output logic [`TPA_PTR_W-1:0] ptrOut
);

    logic [`TPA_LOW_W-1:0] lowInc;
    logic [`TPA_LOW_W-1:0] lowDec;

    always_comb begin
        lowInc = ptrIn[`TPA_LOW_HI:0] + `TPA_LOW_ONE;
        lowDec = ptrIn[`TPA_LOW_HI:0] - `TPA_LOW_ONE;
        accessAddr = ptrIn;
        ptrOut = ptrIn;
        case (mode)
            tpa_pkg::TPA_PTR_KEEP: begin
                ptrOut = ptrIn;
            end
            tpa_pkg::TPA_PTR_POST_INC: begin
                ptrOut = {ptrIn[`TPA_TOP_BIT], lowInc};
            end
            tpa_pkg::TPA_PTR_POST_DEC: begin
                ptrOut = {ptrIn[`TPA_TOP_BIT], lowDec};
            end
            tpa_pkg::TPA_PTR_PRE_INC: begin
                accessAddr = {ptrIn[`TPA_TOP_BIT], lowInc};
                ptrOut = {ptrIn[`TPA_TOP_BIT], lowInc};
            end
            default: begin
                ptrOut = ptrIn;
            end
        endcase
    end

endmodule // tpa_ptr_step

// ### tpa_table_pointer_access.sv
// Table pointer access: transfer latch, pointer, holding registers and word write bus.
// What this block does
// - Eight-bit transfer latch reachable as register.
// - Pointer is 22 bits from three bytes.
// - Low 21 bits memory, top bit config.
// - Automatic updates touch only low 21 bits.
// - Four pointer modes on each table operation.
// - Table read uses all 22 pointer bits.
// - Table write outside word mode picks holding register by bits 6:1, byte lane by bit 0.
// - Write start uses bits 21:10 as block.
// - Erase uses the 12 top bits only.
// - Even word-mode write latches byte, bus floats.
// - Odd write drives latch high, held low.
// - High strobe on odd word-mode writes only, low strobe unused.
// - Byte address shows bit 0, both selects.
// - Word mode affects table writes only; reads ignore it.
`timescale 1ns/1ps
`include "tpa_cfg.svh"

module tpa_table_pointer_access (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic sfrWrEn,
    input wire logic [1:0] sfrSel,
    input wire logic [`TPA_BYTE_W-1:0] sfrWrData,
    input wire logic opValid,
    input wire logic opIsWrite,
    input wire tpa_pkg::tpa_ptr_mode_t opMode,
    input wire logic wordWriteMode,
    input wire logic [`TPA_BYTE_W-1:0] progRdData,
    input wire logic progRdValid,
    input wire logic flashWrStart,
    input wire logic flashEraseSel,
    input wire logic [`TPA_HOLD_AW-1:0] holdRdAddr,
    output logic [`TPA_BYTE_W-1:0] tableTransferLatch,
    output logic [`TPA_BYTE_W-1:0] pointerLowByte,
    output logic [`TPA_BYTE_W-1:0] pointerHighByte,
    output logic [`TPA_BYTE_W-1:0] pointerUpperByte,
    output logic opBusy,
    output logic opDone,
    output logic progRdReq,
    output logic [`TPA_PTR_W-1:0] progRdAddr,
    output logic configSpaceSel,
    output logic flashGo,
    output logic flashErase,
    output logic [`TPA_BLK_W-1:0] flashBlockAddr,
    output logic [`TPA_WORD_W-1:0] holdRdData,
    output logic [`TPA_PTR_W-1:0] extAddr,
    output logic [`TPA_WORD_W-1:0] adOut,
    output logic adOe,
    output logic highWriteStrobe,
    output logic lowWriteStrobe,
    output logic byteAddressPin,
    output logic upperByteSelect,
    output logic lowerByteSelect
);

    // ----------------------------------------------------------------
    // Pointer step and holding memory
    // ----------------------------------------------------------------

    tpa_pkg::tpa_state_t state;
    tpa_pkg::tpa_state_t next_state;
    logic [`TPA_PTR_W-1:0] ptr;
    logic [`TPA_PTR_W-1:0] next_ptr;
    logic [`TPA_PTR_W-1:0] stepAddr;
    logic [`TPA_PTR_W-1:0] stepPtr;
    logic [`TPA_BYTE_W-1:0] next_latch;
    logic [`TPA_BYTE_W-1:0] holdByte;
    logic [`TPA_BYTE_W-1:0] next_holdByte;
    logic accept;
    logic memWe;

    tpa_ptr_step u_step (
        .ptrIn(ptr),
        .mode(opMode),
        .accessAddr(stepAddr),
        .ptrOut(stepPtr)
    );

    assign accept = opValid && (state == tpa_pkg::TPA_ST_IDLE);
    assign memWe = accept && opIsWrite && !wordWriteMode;

    tpa_hold_mem u_hold (
        .core_clk(core_clk),
        .clkEn(clkEn),
        .wrEn(memWe),
        .wrAddr(stepAddr[`TPA_HOLD_HI:`TPA_HOLD_LO]),
        .wrLane(stepAddr[`TPA_LANE_BIT]),
        .wrData(tableTransferLatch),
        .rdAddr(holdRdAddr),
        .rdData(holdRdData)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------

    logic next_opBusy;
    logic next_opDone;
    logic next_progRdReq;
    logic [`TPA_PTR_W-1:0] next_progRdAddr;
    logic next_configSpaceSel;
    logic next_flashGo;
    logic next_flashErase;
    logic [`TPA_BLK_W-1:0] next_flashBlockAddr;
    logic [`TPA_PTR_W-1:0] next_extAddr;
    logic [`TPA_WORD_W-1:0] next_adOut;
    logic next_adOe;
    logic next_highWriteStrobe;
    logic next_byteAddressPin;
    logic next_upperByteSelect;
    logic next_lowerByteSelect;

    always_comb begin
        next_state = state;
        next_ptr = ptr;
        next_latch = tableTransferLatch;
        next_holdByte = holdByte;
        next_opDone = 1'b0;
        next_progRdReq = 1'b0;
        next_progRdAddr = progRdAddr;
        next_configSpaceSel = configSpaceSel;
        next_flashGo = 1'b0;
        next_flashErase = flashErase;
        next_flashBlockAddr = flashBlockAddr;
        next_extAddr = extAddr;
        next_adOut = adOut;
        next_adOe = 1'b0;
        next_highWriteStrobe = 1'b0;
        next_byteAddressPin = byteAddressPin;
        next_upperByteSelect = 1'b0;
        next_lowerByteSelect = 1'b0;

        if (sfrWrEn) begin
            case (sfrSel)
                `TPA_SFR_LATCH: begin
                    next_latch = sfrWrData;
                end
                `TPA_SFR_PTR_LOW: begin
                    next_ptr[`TPA_BYTE_W-1:0] = sfrWrData;
                end
                `TPA_SFR_PTR_HIGH: begin
                    next_ptr[`TPA_WORD_W-1:`TPA_BYTE_W] = sfrWrData;
                end
                `TPA_SFR_PTR_UPPER: begin
                    next_ptr[`TPA_PTR_W-1:`TPA_WORD_W] = sfrWrData[`TPA_UPPER_USED-1:0];
                end
                default: begin
                    next_ptr = ptr;
                end
            endcase
        end

        if (flashWrStart) begin
            next_flashGo = 1'b1;
            next_flashErase = flashEraseSel;
            next_flashBlockAddr = ptr[`TPA_BLK_HI:`TPA_BLK_LO];
        end

        case (state)
            tpa_pkg::TPA_ST_IDLE: begin
                if (accept) begin
                    next_ptr = stepPtr;
                    if (!opIsWrite) begin
                        next_progRdReq = 1'b1;
                        next_progRdAddr = stepAddr;
                        next_configSpaceSel = stepAddr[`TPA_TOP_BIT];
                        next_state = tpa_pkg::TPA_ST_RD_WAIT;
                    end else if (wordWriteMode) begin
                        next_extAddr = stepAddr;
                        next_byteAddressPin = stepAddr[`TPA_LANE_BIT];
                        next_state = tpa_pkg::TPA_ST_EXT_CYCLE;
                        if (stepAddr[`TPA_LANE_BIT]) begin
                            next_adOut = {tableTransferLatch, holdByte};
                            next_adOe = 1'b1;
                            next_highWriteStrobe = 1'b1;
                            next_upperByteSelect = 1'b1;
                            next_lowerByteSelect = 1'b1;
                        end else begin
                            next_holdByte = tableTransferLatch;
                        end
                    end else begin
                        next_opDone = 1'b1;
                    end
                end
            end
            tpa_pkg::TPA_ST_RD_WAIT: begin
                if (progRdValid) begin
                    next_latch = progRdData;
                    next_opDone = 1'b1;
                    next_state = tpa_pkg::TPA_ST_IDLE;
                end
            end
            tpa_pkg::TPA_ST_EXT_CYCLE: begin
                next_opDone = 1'b1;
                next_state = tpa_pkg::TPA_ST_IDLE;
            end
            default: begin
                next_state = tpa_pkg::TPA_ST_IDLE;
            end
        endcase

        next_opBusy = (next_state != tpa_pkg::TPA_ST_IDLE);
    end

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= tpa_pkg::TPA_ST_IDLE;
            ptr <= `TPA_PTR_RST;
            tableTransferLatch <= `TPA_BYTE_RST;
            holdByte <= `TPA_BYTE_RST;
            opBusy <= 1'b0;
            opDone <= 1'b0;
            progRdReq <= 1'b0;
            progRdAddr <= `TPA_PTR_RST;
            configSpaceSel <= 1'b0;
            flashGo <= 1'b0;
            flashErase <= 1'b0;
            flashBlockAddr <= `TPA_BLK_RST;
            extAddr <= `TPA_PTR_RST;
            adOut <= `TPA_WORD_RST;
            adOe <= 1'b0;
            highWriteStrobe <= 1'b0;
            lowWriteStrobe <= 1'b0;
            byteAddressPin <= 1'b0;
            upperByteSelect <= 1'b0;
            lowerByteSelect <= 1'b0;
        end else if (clkEn) begin
            state <= next_state;
            ptr <= next_ptr;
            tableTransferLatch <= next_latch;
            holdByte <= next_holdByte;
            opBusy <= next_opBusy;
            opDone <= next_opDone;
            progRdReq <= next_progRdReq;
            progRdAddr <= next_progRdAddr;
            configSpaceSel <= next_configSpaceSel;
            flashGo <= next_flashGo;
            flashErase <= next_flashErase;
            flashBlockAddr <= next_flashBlockAddr;
            extAddr <= next_extAddr;
            adOut <= next_adOut;
            adOe <= next_adOe;
            highWriteStrobe <= next_highWriteStrobe;
            lowWriteStrobe <= 1'b0;
            byteAddressPin <= next_byteAddressPin;
            upperByteSelect <= next_upperByteSelect;
            lowerByteSelect <= next_lowerByteSelect;
        end
    end

    // ----------------------------------------------------------------
    // Register read views
    // ----------------------------------------------------------------

    assign pointerLowByte = ptr[`TPA_BYTE_W-1:0];
    assign pointerHighByte = ptr[`TPA_WORD_W-1:`TPA_BYTE_W];
    assign pointerUpperByte = {`TPA_UPPER_PAD, ptr[`TPA_PTR_W-1:`TPA_WORD_W]};

endmodule // tpa_table_pointer_access

// ### tpa_table_pointer_access_properties.sv
// Assertions for the table pointer access block, bound to its top module.
`timescale 1ns/1ps
`include "tpa_cfg.svh"

module tpa_table_pointer_access_properties (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic opValid,
    input wire logic opIsWrite,
    input wire tpa_pkg::tpa_ptr_mode_t opMode,
    input wire logic wordWriteMode,
    input wire logic [7:0] progRdData,
    input wire logic progRdValid,
    input wire logic flashWrStart,
    input wire logic flashEraseSel,
    input wire logic [7:0] tableTransferLatch,
    input wire logic [7:0] pointerLowByte,
    input wire logic [7:0] pointerHighByte,
    input wire logic [7:0] pointerUpperByte,
    input wire logic opBusy,
    input wire logic opDone,
    input wire logic progRdReq,
    input wire logic [21:0] progRdAddr,
    input wire logic configSpaceSel,
    input wire logic flashGo,
    input wire logic flashErase,
    input wire logic [11:0] flashBlockAddr,
    input wire logic [15:0] adOut,
    input wire logic adOe,
    input wire logic highWriteStrobe,
    input wire logic lowWriteStrobe,
    input wire logic byteAddressPin,
    input wire logic upperByteSelect,
    input wire logic lowerByteSelect
);
    // ----------------------------------------
    // Expected pointer step and access address.
    // ----------------------------------------
    logic [21:0] ptr;
    logic [21:0] acc;
    logic [20:0] nextLow;
    logic take;
    assign ptr = {pointerUpperByte[5:0], pointerHighByte, pointerLowByte};
    assign take = opValid && !opBusy && clkEn;
    assign acc = (opMode == tpa_pkg::TPA_PTR_PRE_INC) ? {ptr[21], nextLow} : ptr;
    always_comb begin
        case (opMode)
            tpa_pkg::TPA_PTR_KEEP: nextLow = ptr[20:0];
            tpa_pkg::TPA_PTR_POST_DEC: nextLow = ptr[20:0] - 21'h1;
            default: nextLow = ptr[20:0] + 21'h1;
        endcase
    end

    // ----------------------------------------
    // Properties.
    // ----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence evenCycle;
        !adOe && !highWriteStrobe && !byteAddressPin ##1 opDone && !adOe;
    endsequence
    sequence oddCycle;
        highWriteStrobe && adOe && byteAddressPin ##1 opDone && !highWriteStrobe;
    endsequence

    ptr_step_a: assert property (take |=> ptr == {$past(ptr[21]), $past(nextLow)})
        else $error("pointer step wrong");
    rd_issue_a: assert property (take && !opIsWrite |=> progRdReq && progRdAddr == $past(acc))
        else $error("read request wrong");
    latch_load_a: assert property (opBusy && progRdValid && clkEn && !adOe
        |=> opDone && tableTransferLatch == $past(progRdData)) else $error("latch not loaded");
    cfg_space_a: assert property (progRdReq |-> configSpaceSel == progRdAddr[21])
        else $error("config select wrong");
    int_write_a: assert property (take && opIsWrite && !wordWriteMode |=> opDone)
        else $error("internal write not done");
    even_write_a: assert property (take && opIsWrite && wordWriteMode && !acc[0] |=> evenCycle)
        else $error("even write drove bus");
    odd_write_a: assert property (take && opIsWrite && wordWriteMode && acc[0]
        |=> adOut[15:8] == $past(tableTransferLatch) ##0 oddCycle) else $error("odd write bad");
    strobe_group_a: assert property (highWriteStrobe |-> upperByteSelect && lowerByteSelect)
        else $error("byte selects missing");
    low_strobe_a: assert property (!lowWriteStrobe)
        else $error("low strobe used");
    flash_go_a: assert property (flashWrStart && clkEn |=> flashGo &&
        flashErase == $past(flashEraseSel) && flashBlockAddr == $past(ptr[21:10]))
        else $error("flash start wrong");
endmodule // tpa_table_pointer_access_properties

bind tpa_table_pointer_access tpa_table_pointer_access_properties
    tpa_table_pointer_access_properties_inst (.*);
